//--- logic/sbsti_consts.svh
`ifndef SBSTI_CONSTS_SVH
`define SBSTI_CONSTS_SVH
`define SBSTI_IR_W 3
`define SBSTI_IR_EXTEST 3'h0
`define SBSTI_IR_IDCODE 3'h1
`define SBSTI_IR_SAMPZ 3'h2
`define SBSTI_IR_SAMPLE 3'h4
`define SBSTI_IR_BYPASS 3'h7
`define SBSTI_IR_CAPTURE 3'h1
`define SBSTI_ID_W 32
`define SBSTI_BSR_W 109
`define SBSTI_OE_BIT 108
`define SBSTI_PIN_W 108
`define SBSTI_ID_VALUE 32'h0000_0a5b
`define SBSTI_TCK_MAX_MHZ 20
`endif

//--- logic/sbsti_pkg.sv
`include "sbsti_consts.svh"
package sbsti_pkg;
  typedef enum logic [15:0] {
    SBSTI_TLR = 16'h0001, SBSTI_RTI = 16'h0002, SBSTI_SELDR = 16'h0004,
    SBSTI_CAPDR = 16'h0008, SBSTI_SHDR = 16'h0010, SBSTI_EX1DR = 16'h0020,
    SBSTI_PADR = 16'h0040, SBSTI_EX2DR = 16'h0080, SBSTI_UPDR = 16'h0100,
    SBSTI_SELIR = 16'h0200, SBSTI_CAPIR = 16'h0400, SBSTI_SHIR = 16'h0800,
    SBSTI_EX1IR = 16'h1000, SBSTI_PAIR = 16'h2000, SBSTI_EX2IR = 16'h4000,
    SBSTI_UPIR = 16'h8000
  } sbsti_state_e;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbsti_jtag_s;
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } sbsti_tdo_s;
endpackage : sbsti_pkg

//--- logic/sbsti_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sbsti_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Raw and synchronised pins
  input wire logic [3:0] raw,
  output logic [3:0] sync
);
  logic [3:0] stage;
  always_ff @(posedge clock) begin
    if (reset) begin
      stage <= 4'h0;
      sync <= 4'h0;
    end else begin
      stage <= raw;
      sync <= stage;
    end
  end
endmodule : sbsti_sync
`default_nettype wire

//--- logic/sbsti_fsm.sv
`timescale 1ns/10ps
`default_nettype none
module sbsti_fsm
  import sbsti_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Test clock rising edge and mode select
  input wire logic tck_rise,
  input wire logic tms,
  // State
  output sbsti_pkg::sbsti_state_e state
);
  import sbsti_pkg::*;
  sbsti_state_e next_state;
  always_comb begin
    case (state)
      SBSTI_TLR: next_state = tms ? SBSTI_TLR : SBSTI_RTI;
      SBSTI_RTI: next_state = tms ? SBSTI_SELDR : SBSTI_RTI;
      SBSTI_SELDR: next_state = tms ? SBSTI_SELIR : SBSTI_CAPDR;
      SBSTI_CAPDR: next_state = tms ? SBSTI_EX1DR : SBSTI_SHDR;
      SBSTI_SHDR: next_state = tms ? SBSTI_EX1DR : SBSTI_SHDR;
      SBSTI_EX1DR: next_state = tms ? SBSTI_UPDR : SBSTI_PADR;
      SBSTI_PADR: next_state = tms ? SBSTI_EX2DR : SBSTI_PADR;
      SBSTI_EX2DR: next_state = tms ? SBSTI_UPDR : SBSTI_SHDR;
      SBSTI_UPDR: next_state = tms ? SBSTI_SELDR : SBSTI_RTI;
      SBSTI_SELIR: next_state = tms ? SBSTI_TLR : SBSTI_CAPIR;
      SBSTI_CAPIR: next_state = tms ? SBSTI_EX1IR : SBSTI_SHIR;
      SBSTI_SHIR: next_state = tms ? SBSTI_EX1IR : SBSTI_SHIR;
      SBSTI_EX1IR: next_state = tms ? SBSTI_UPIR : SBSTI_PAIR;
      SBSTI_PAIR: next_state = tms ? SBSTI_EX2IR : SBSTI_PAIR;
      SBSTI_EX2IR: next_state = tms ? SBSTI_UPIR : SBSTI_SHIR;
      SBSTI_UPIR: next_state = tms ? SBSTI_SELDR : SBSTI_RTI;
      default: next_state = SBSTI_TLR;
    endcase
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= SBSTI_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end
endmodule : sbsti_fsm
`default_nettype wire

//--- logic/sbsti_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbsti_consts.svh"
module sbsti_top
  import sbsti_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Test port pins
  input wire sbsti_pkg::sbsti_jtag_s JTAG,
  output sbsti_pkg::sbsti_tdo_s TDO,
  // Parallel pin ring, memory side
  input wire logic [`SBSTI_PIN_W-1:0] PIN_IN,
  input wire logic [`SBSTI_PIN_W-1:0] CORE_OUT,
  input wire logic CORE_Q_OE,
  // Pins as driven
  output logic [`SBSTI_PIN_W-1:0] PIN_OUT,
  output logic Q_OE
);
  import sbsti_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and test clock edges
  logic [3:0] pins_sync;
  logic tck_q;
  logic tck;
  logic tms;
  logic tdi;
  wire tck_rise = tck & ~tck_q;
  wire tck_fall = ~tck & tck_q;
  assign tck = pins_sync[2];
  assign tms = pins_sync[1];
  assign tdi = pins_sync[0];

  sbsti_sync u_sync (
    .clock(CLOCK),
    .reset(RESET),
    .raw({1'b0, JTAG.tck, JTAG.tms, JTAG.tdi}),
    .sync(pins_sync)
  );

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine
  sbsti_state_e state;
  sbsti_fsm u_fsm (
    .clock(CLOCK),
    .reset(RESET),
    .tck_rise(tck_rise),
    .tms(tms),
    .state(state)
  );
  wire in_tlr = (state == SBSTI_TLR);
  wire in_capir = (state == SBSTI_CAPIR);
  wire in_shir = (state == SBSTI_SHIR);
  wire in_upir = (state == SBSTI_UPIR);
  wire in_capdr = (state == SBSTI_CAPDR);
  wire in_shdr = (state == SBSTI_SHDR);
  wire in_updr = (state == SBSTI_UPDR);

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  function automatic logic is_boundary(input logic [2:0] code);
    is_boundary = (code == `SBSTI_IR_EXTEST) || (code == `SBSTI_IR_SAMPZ) ||
                  (code == `SBSTI_IR_SAMPLE);
  endfunction : is_boundary

  wire [`SBSTI_IR_W-1:0] ir_shift;
  logic [`SBSTI_IR_W-1:0] ir;
  wire sel_id = (ir == `SBSTI_IR_IDCODE);
  wire sel_bsr = is_boundary(ir);
  wire sel_byp = ~sel_id & ~sel_bsr;
  wire mode_extest = (ir == `SBSTI_IR_EXTEST);
  wire mode_sampz = (ir == `SBSTI_IR_SAMPZ);

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register strobes
  wire ir_cap;
  wire ir_sh;
  wire ir_upd;
  wire [`SBSTI_IR_W-1:0] ir_reset;
  wire [`SBSTI_IR_W-1:0] ir_capture;
  wire [`SBSTI_IR_W-1:0] ir_next_in;

  assign ir_cap = tck_rise & in_capir;
  assign ir_sh = tck_rise & in_shir;
  // Update waits for the fall inside Update-IR, after the rise has settled
  assign ir_upd = tck_fall & in_upir;
  assign ir_reset = `SBSTI_IR_IDCODE;
  assign ir_capture = `SBSTI_IR_CAPTURE;
  assign ir_next_in = {tdi, ir_shift[`SBSTI_IR_W-1:1]};

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register
  // Each cell captures, shifts toward the data out end, or holds
  // three-bit shift and hold stages
  genvar gr;
  generate
    for (gr = 0; gr < `SBSTI_IR_W; gr++) begin : g_ir
      logic ir_cell;

      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          ir_cell <= ir_reset[gr];
        end else if (ir_cap) begin
          ir_cell <= ir_capture[gr];
        end else if (ir_sh) begin
          ir_cell <= ir_next_in[gr];
        end
      end

      assign ir_shift[gr] = ir_cell;
    end
  endgenerate

  // The held instruction drives all decode; the shift stage feeds it and data out in Shift-IR
  // Test-Logic-Reset wins over any update for as long as it lasts
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ir <= `SBSTI_IR_IDCODE;
    end else if (in_tlr) begin
      ir <= `SBSTI_IR_IDCODE;
    end else if (ir_upd) begin
      ir <= ir_shift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data register strobes
  // Each strobe is one system clock wide, once per test clock edge
  wire id_cap;
  wire id_sh;
  wire byp_cap;
  wire byp_sh;
  wire bsr_cap;
  wire bsr_sh;
  wire bsr_upd;

  assign id_cap = tck_rise & in_capdr & sel_id;
  assign id_sh = tck_rise & in_shdr & sel_id;
  assign byp_cap = tck_rise & in_capdr & sel_byp;
  assign byp_sh = tck_rise & in_shdr & sel_byp;
  assign bsr_cap = tck_rise & in_capdr & sel_bsr;
  assign bsr_sh = tck_rise & in_shdr & sel_bsr;
  assign bsr_upd = tck_fall & in_updr & sel_bsr;

  ////////////////////////////////////////////////////////////////////////////
  // Identification register
  wire [`SBSTI_ID_W-1:0] id_shift;
  wire [`SBSTI_ID_W-1:0] id_code;
  wire [`SBSTI_ID_W-1:0] id_next_in;

  // The code is an arbitrary neutral value that names no maker
  assign id_code = `SBSTI_ID_VALUE;
  assign id_next_in = {tdi, id_shift[`SBSTI_ID_W-1:1]};

  genvar gi;
  generate
    for (gi = 0; gi < `SBSTI_ID_W; gi++) begin : g_id
      logic id_cell;

      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          id_cell <= id_code[gi];
        end else if (id_cap) begin
          id_cell <= id_code[gi];
        end else if (id_sh) begin
          id_cell <= id_next_in[gi];
        end
      end

      assign id_shift[gi] = id_cell;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Bypass register
  // One bit of delay per device on a shared chain
  logic byp;

  // Cleared at Capture-DR so every bypass pass leads with a zero
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      byp <= 1'b0;
    end else if (byp_cap) begin
      byp <= 1'b0;
    end else if (byp_sh) begin
      byp <= tdi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary register, one shift stage and one preload latch per cell
  wire [`SBSTI_BSR_W-1:0] bsr_shift;
  wire [`SBSTI_BSR_W-1:0] bsr_latch;
  wire [`SBSTI_BSR_W-1:0] ring;
  wire [`SBSTI_BSR_W-1:0] bsr_next_in;
  wire [`SBSTI_BSR_W-1:0] latch_preset;

  assign ring = {CORE_Q_OE, PIN_IN};
  assign bsr_next_in = {tdi, bsr_shift[`SBSTI_BSR_W-1:1]};
  // Only the enable cell powers up high and is preset in Test-Logic-Reset
  assign latch_preset = {1'b1, {`SBSTI_PIN_W{1'b0}}};

  // A capture is only as good as the ring is quiet around the test rise
  genvar gb;
  generate
    for (gb = 0; gb < `SBSTI_BSR_W; gb++) begin : g_cell
      logic shift_stage;
      logic preload;

      // Shift stage starts low; its value matters only after a capture
      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          shift_stage <= 1'b0;
        end else if (bsr_cap) begin
          shift_stage <= ring[gb];
        end else if (bsr_sh) begin
          // shift in and out at once
          shift_stage <= bsr_next_in[gb];
        end
      end

      // Latch holds between updates so pins do not ripple while shifting
      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          preload <= latch_preset[gb];
        end else if (in_tlr && latch_preset[gb]) begin
          preload <= 1'b1;
        end else if (bsr_upd) begin
          preload <= shift_stage;
        end
      end

      assign bsr_shift[gb] = shift_stage;
      assign bsr_latch[gb] = preload;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Test data out
  wire shifting;
  wire dr_bit;
  wire next_tdo;

  // Enable marks the cycles in which the pin carries register data
  assign shifting = in_shir | in_shdr;
  // Instruction path only in Shift-IR, else the selected data register
  assign dr_bit = sel_id ? id_shift[0] : (sel_bsr ? bsr_shift[0] : byp);
  assign next_tdo = in_shir ? ir_shift[0] : dr_bit;

  // Driven on the fall so the far side samples it settled at the next rise
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      TDO <= 2'h0;
    end else if (tck_fall) begin
      TDO <= {next_tdo, shifting};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System pins
  wire extest_oe;
  wire q_oe_override;
  wire next_q_oe;
  wire [`SBSTI_PIN_W-1:0] next_pin_out;

  assign extest_oe = bsr_latch[`SBSTI_OE_BIT];
  assign q_oe_override = mode_sampz | mode_extest;
  // bit 108 under extest, high drives, high-Z sample
  assign next_q_oe = q_oe_override ? (mode_extest & extest_oe) : CORE_Q_OE;

  // Outside external test the pins follow the core one clock late
  genvar gp;
  generate
    for (gp = 0; gp < `SBSTI_PIN_W; gp++) begin : g_pin
      assign next_pin_out[gp] = mode_extest ? bsr_latch[gp] : CORE_OUT[gp];
    end
  endgenerate

  // Registered so the pin ring never sees a decode glitch
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      PIN_OUT <= {`SBSTI_PIN_W{1'b0}};
    end else begin
      PIN_OUT <= next_pin_out;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      Q_OE <= 1'b0;
    end else begin
      Q_OE <= next_q_oe;
    end
  end
endmodule : sbsti_top
`default_nettype wire

//--- sim/sbsti_top_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbsti_consts.svh"
module sbsti_top_props
  import sbsti_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Test port
  input wire sbsti_pkg::sbsti_jtag_s JTAG,
  input wire sbsti_pkg::sbsti_tdo_s TDO,
  // Pin ring
  input wire logic [`SBSTI_PIN_W-1:0] PIN_IN,
  input wire logic [`SBSTI_PIN_W-1:0] CORE_OUT,
  input wire logic CORE_Q_OE,
  input wire logic [`SBSTI_PIN_W-1:0] PIN_OUT,
  input wire logic Q_OE
);
  logic seen;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // Any test clock activity since reset
  always_ff @(posedge CLOCK) begin
    if (RESET) seen <= 1'b0;
    else if (JTAG.tck) seen <= 1'b1;
  end
  reset_quiet_a: assert property (disable iff (1'b0)
    RESET |=> TDO == '0 && PIN_OUT == '0 && !Q_OE)
    else $error("outputs not cleared by reset");
  idle_pins_a: assert property (
    !seen && !$past(RESET) |-> PIN_OUT == $past(CORE_OUT))
    else $error("pins not following core after reset");
  idle_qoe_a: assert property (
    !seen && !$past(RESET) |-> Q_OE == $past(CORE_Q_OE))
    else $error("read bus enable not following core");
  tdo_fall_a: assert property (
    $changed(TDO.tdo) |-> !JTAG.tck && $past(JTAG.tck, 6))
    else $error("data out moved away from a falling edge");
  tdo_oe_fall_a: assert property (
    $changed(TDO.tdo_oe) |-> !JTAG.tck && $past(JTAG.tck, 6))
    else $error("data out enable moved off a falling edge");
  tdo_idle_a: assert property (
    !JTAG.tck [*8] |-> $stable(TDO))
    else $error("data out moved with test clock idle");
  pin_latch_a: assert property (
    $changed(PIN_OUT) && PIN_OUT != $past(CORE_OUT) |-> !JTAG.tck)
    else $error("latched pins changed on a rising half");
  qoe_latch_a: assert property (
    $changed(Q_OE) && Q_OE != $past(CORE_Q_OE) |-> !JTAG.tck)
    else $error("bus enable override changed on a rising half");
endmodule : sbsti_top_props
bind sbsti_top sbsti_top_props sbsti_top_props_i (.CLOCK(CLOCK),
  .RESET(RESET), .JTAG(JTAG), .TDO(TDO), .PIN_IN(PIN_IN),
  .CORE_OUT(CORE_OUT), .CORE_Q_OE(CORE_Q_OE), .PIN_OUT(PIN_OUT),
  .Q_OE(Q_OE));
`default_nettype wire

//--- sim/sbsti_scan_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module sbsti_scan_ctl (
  // Test port drive
  output logic tck,
  output logic tms,
  output logic tdi,
  // Serial data back
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 64 ns clock, inputs held round the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #32;
    q = tdo;
    tck = 1'b1;
    #32;
    tck = 1'b0;
    tdi = 1'b1;
  endtask : step
  // five high mode clocks, then idle
  task automatic tlr();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : tlr
  // capture, shift, update, back to idle
  task automatic scan(input logic ir, input int n,
    input logic [127:0] din, output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan
endmodule : sbsti_scan_ctl
`default_nettype wire

//--- sim/sbsti_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbsti_consts.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin \
  fail_count++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module sbsti_top_tb_top;
  import sbsti_pkg::*;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  wire tck, tms, tdi;
  wire sbsti_jtag_s jtag = {tck, tms, tdi};
  sbsti_tdo_s tdo_bus;
  logic [`SBSTI_PIN_W-1:0] pin_in = '0, core_out = '0, pin_out;
  logic core_q_oe = 1'b0, q_oe;
  logic [127:0] din, dout;
  logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
  int fail_count = 0, samples_checked = 0;
  always #2.5 CLOCK = ~CLOCK;
  sbsti_scan_ctl sbsti_scan_ctl_i (.tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo_bus.tdo));
  sbsti_top sbsti_top_i (.CLOCK(CLOCK), .RESET(RESET), .JTAG(jtag),
    .TDO(tdo_bus), .PIN_IN(pin_in), .CORE_OUT(core_out),
    .CORE_Q_OE(core_q_oe), .PIN_OUT(pin_out), .Q_OE(q_oe));
  function automatic logic [127:0] rnd();
    return {$urandom, $urandom, $urandom, $urandom};
  endfunction : rnd
  task automatic pins();
    logic [127:0] r;
    r = rnd();
    @(posedge CLOCK);
    pin_in <= r[`SBSTI_PIN_W-1:0];
    core_out <= r[127:20];
    core_q_oe <= r[0];
  endtask : pins
  task automatic ir_load(input logic [2:0] c);
    logic [127:0] o;
    sbsti_scan_ctl_i.scan(1'b1, 3, {125'h0, c}, o);
    `CHK("ir capture", 2'b01, o[1:0])
  endtask : ir_load
  task automatic print_verdict();
    $display("fail_count %0d samples_checked %0d", fail_count,
      samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hbf28bf92));
    repeat (20) @(posedge CLOCK);
    RESET <= 1'b0;
    pins();
    repeat (40) @(posedge CLOCK);
    sbsti_scan_ctl_i.tlr();
    sbsti_scan_ctl_i.scan(1'b0, 32, rnd(), dout);
    `CHK("idcode", `SBSTI_ID_VALUE, dout[31:0])
    `CHK("tdo idle", 1'b0, tdo_bus.tdo_oe)
    for (int k = 0; k < 2; k++) begin
      pins();
      ir_load(`SBSTI_IR_SAMPLE);
      din = rnd();
      din[`SBSTI_OE_BIT] = ~k[0];
      sbsti_scan_ctl_i.scan(1'b0, `SBSTI_BSR_W, din, dout);
      `CHK("sample", {core_q_oe, pin_in}, dout[108:0])
      `CHK("sample pins", core_out, pin_out)
      ir_load(`SBSTI_IR_EXTEST);
      `CHK("extest pins", din[107:0], pin_out)
      `CHK("extest oe", din[108], q_oe)
    end
    sbsti_scan_ctl_i.tlr();
    `CHK("reset oe", core_q_oe, q_oe)
    ir_load(`SBSTI_IR_EXTEST);
    `CHK("preset oe", 1'b1, q_oe)
    `CHK("held preload", din[107:0], pin_out)
    pins();
    @(posedge CLOCK) core_q_oe <= 1'b1;
    ir_load(`SBSTI_IR_SAMPZ);
    `CHK("sampz oe", 1'b0, q_oe)
    sbsti_scan_ctl_i.scan(1'b0, `SBSTI_BSR_W, rnd(), dout);
    `CHK("sampz scan", pin_in, dout[107:0])
    `CHK("sampz oe held", 1'b0, q_oe)
    for (int k = 0; k < 4; k++) begin
      pins();
      ir_load(codes[k]);
      din = rnd();
      sbsti_scan_ctl_i.scan(1'b0, 2, din, dout);
      `CHK("bypass", {din[0], 1'b0}, dout[1:0])
      `CHK("bypass pins", core_out, pin_out)
      `CHK("bypass oe", core_q_oe, q_oe)
    end
    print_verdict();
  end
endmodule : sbsti_top_tb_top
`default_nettype wire
